/* File: hdl/cesm_map.svh */
// constants for the bus-port error status monitor: indices, fields, resets
// assumes it is included by bare name where indices or thresholds are needed
`ifndef CESM_MAP_SVH
`define CESM_MAP_SVH

// parameter indices on the access port
`define CESM_IDX_GROUP_ENTRIES 16'h0422
`define CESM_IDX_STATUS 16'h0424
`define CESM_IDX_COUNT_A 16'h0426
`define CESM_IDX_COUNT_B 16'h0428
`define CESM_IDX_EMCY_ENTRIES 16'h0438
`define CESM_IDX_EMCY_SERVICE 16'h043a
`define CESM_IDX_EMCY_PROCESS 16'h043c
`define CESM_IDX_EMCY_DEVICE 16'h043e

// status word field positions
`define CESM_BIT_WARNING 0
`define CESM_BIT_PASSIVE 1
`define CESM_BIT_BUS_OFF 2
`define CESM_BIT_ERR_LO 3
`define CESM_BIT_ERR_HI 8
`define CESM_BIT_RSV_LO 9
`define CESM_BIT_RSV_HI 15
`define CESM_BIT_TEC_LO 16
`define CESM_BIT_TEC_HI 23
`define CESM_BIT_REC_LO 24
`define CESM_BIT_REC_HI 31

// fault-confinement thresholds, at the 9-bit counter width
`define CESM_LIM_WARNING 9'h060
`define CESM_LIM_PASSIVE 9'h080
`define CESM_LIM_BUS_OFF 9'h100

// reset and constant values
`define CESM_GROUP_ENTRIES 8'h05
`define CESM_EMCY_ENTRIES_RST 8'h03
`define CESM_WORD_RST 32'h0000_0000
`define CESM_COMM_FAULT_MASK 32'h0000_0001

`endif

/* File: hdl/cesm_pkg.sv */
// types shared by the status monitor modules
// assumes nothing beyond a SystemVerilog compiler
package cesm_pkg;

    // error-type flags as they sit in bits 3..8 of the status word
    typedef struct packed {
        logic form_err;
        logic bit_err;
        logic stuck_dom;
        logic crc_err;
        logic stuff_err;
        logic ack_err;
    } cesm_err_s;

    // full status word layout, msb first
    typedef struct packed {
        logic [7:0] rec;
        logic [7:0] tec;
        logic [6:0] reserved;
        cesm_err_s errs;
        logic bus_off;
        logic passive;
        logic warning;
    } cesm_status_s;

endpackage

/* File: hdl/cesm_word_if.sv */
// carrier for one 32-bit held word: event with data, software load, value
// assumes owner and user run on the same clock
`timescale 1ns/1ps
interface cesm_word_if;
    logic evt;
    logic [31:0] evt_data;
    logic load;
    logic [31:0] load_data;
    logic [31:0] value;

    modport owner(input evt, input evt_data, input load, input load_data, output value);
    modport user(output evt, output evt_data, output load, output load_data, input value);
endinterface

/* File: hdl/cesm_frame_counter.sv */
// 32-bit error-frame counter, loadable by software
// assumes evt is a one-cycle pulse per detected error frame
`timescale 1ns/1ps
`include "cesm_map.svh"
module cesm_frame_counter (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // held word
    cesm_word_if.owner w
);

    // a frame seen in the write cycle counts on top of the written value
    always_ff @(posedge clk) begin
        if (rst) begin
            w.value <= `CESM_WORD_RST;
        end else if (w.load) begin
            w.value <= w.load_data + {31'h0000_0000, w.evt};
        end else if (w.evt) begin
            w.value <= w.value + 32'h0000_0001; // wraps past all ones
        end
    end

endmodule

/* File: hdl/cesm_emcy_record.sv */
// 32-bit emergency detail record: sticky capture, cleared by software
// assumes evt_data carries only the detail bits of the new emergency
`timescale 1ns/1ps
`include "cesm_map.svh"
module cesm_emcy_record (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // held word
    cesm_word_if.owner w
);

    // capture beats clear: a clear drops old detail but keeps the new one
    always_ff @(posedge clk) begin
        if (rst) begin
            w.value <= `CESM_WORD_RST;
        end else if (w.evt && w.load) begin
            w.value <= w.evt_data;
        end else if (w.evt) begin
            w.value <= w.value | w.evt_data;
        end else if (w.load) begin
            w.value <= w.load_data;
        end
    end

endmodule

/* File: hdl/cesm_monitor.sv */
// bus-port error status monitor: status word, frame counters, emergency records
// assumes the protocol controller and emergency sources share REF_CLK
//
// Overview of operation
// - status bit 0 is set while either error counter is 96 or more.
// - status bit 1 is set while the transmit error counter is 128 or more.
// - status bit 2 is set at a count of 256 and then transmit and receive are both blocked.
// - bits 3 to 8 flag acknowledge, stuff, crc, stuck-dominant, bit and form errors.
// - bits 16 to 23 carry the transmit error counter, held at 255 from a count of 256.
// - bits 24 to 31 carry the receive error counter.
// - the status word is a 32-bit value that software reads and cannot change.
// - two 32-bit error-frame counters count error frames and are read and written by software.
// - any write to the emergency entry count clears all three detail records.
// - one read-only record holds details of service-object emergencies.
// - a second read-only record holds details of process-data emergencies.
// - a third read-only record holds main-fault emergencies without comm errors.
// - the counter group reads a fixed 5 and the emergency group reads 3 after reset.
`timescale 1ns/1ps
`include "cesm_map.svh"
module cesm_monitor (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    // protocol controller
    input wire logic [8:0] TX_ERR_CNT,
    input wire logic [7:0] RX_ERR_CNT,
    input wire logic [5:0] ERR_TYPE,
    input wire logic TX_ERR_FRAME,
    input wire logic RX_ERR_FRAME,
    // emergency sources
    input wire logic EMCY_SVC_EVT,
    input wire logic [31:0] EMCY_SVC_DATA,
    input wire logic EMCY_PDO_EVT,
    input wire logic [31:0] EMCY_PDO_DATA,
    input wire logic [31:0] MAIN_FAULT_WORD,
    // parameter access port
    input wire logic [15:0] PAR_INDEX,
    input wire logic PAR_RD,
    input wire logic PAR_WR,
    input wire logic [31:0] PAR_WDATA,
    output logic [31:0] PAR_RDATA,
    output logic PAR_ACK,
    output logic PAR_ERR,
    // bus gating and live status
    output logic TX_ENABLE,
    output logic RX_ENABLE,
    output logic [31:0] STATUS_WORD
);

    cesm_pkg::cesm_status_s status;
    cesm_pkg::cesm_status_s next_status;
    logic [7:0] emcy_entries;
    logic [31:0] next_rdata;
    logic next_err;
    logic [31:0] dev_detail;

    cesm_word_if cnt_a ();
    cesm_word_if cnt_b ();
    cesm_word_if rec_svc ();
    cesm_word_if rec_pdo ();
    cesm_word_if rec_dev ();

    // transmit counter shown in 8 bits; bus-off is flagged separately
    function automatic logic [7:0] tec_field(input logic [8:0] tec);
        tec_field = (tec > 9'h0ff) ? 8'hff : tec[7:0];
    endfunction

    // true for every index this block answers to
    function automatic logic index_hit(input logic [15:0] idx);
        index_hit = (idx == `CESM_IDX_GROUP_ENTRIES) || (idx == `CESM_IDX_STATUS) ||
                    (idx == `CESM_IDX_COUNT_A) || (idx == `CESM_IDX_COUNT_B) ||
                    (idx == `CESM_IDX_EMCY_ENTRIES) || (idx == `CESM_IDX_EMCY_SERVICE) ||
                    (idx == `CESM_IDX_EMCY_PROCESS) || (idx == `CESM_IDX_EMCY_DEVICE);
    endfunction

    // true for indices that software may write
    function automatic logic index_writable(input logic [15:0] idx);
        index_writable = (idx == `CESM_IDX_COUNT_A) || (idx == `CESM_IDX_COUNT_B) ||
                         (idx == `CESM_IDX_EMCY_ENTRIES);
    endfunction

    // next status word from the live controller values
    always_comb begin
        next_status = '0;
        next_status.warning = (TX_ERR_CNT >= `CESM_LIM_WARNING) ||
                              ({1'b0, RX_ERR_CNT} >= `CESM_LIM_WARNING);
        next_status.passive = (TX_ERR_CNT >= `CESM_LIM_PASSIVE);
        next_status.bus_off = (TX_ERR_CNT >= `CESM_LIM_BUS_OFF);
        next_status.errs = ERR_TYPE;
        next_status.reserved = 7'h00;
        next_status.tec = tec_field(TX_ERR_CNT);
        next_status.rec = RX_ERR_CNT;
    end

    // refreshed every cycle, so it never lags the controller by more than one
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            status <= '0;
        end else begin
            status <= next_status;
        end
    end

    // no write path reaches status; only the controller inputs move it
    assign STATUS_WORD = status;

    // bus-off blocks both directions until the controller recovers
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            TX_ENABLE <= 1'b0;
            RX_ENABLE <= 1'b0;
        end else begin
            TX_ENABLE <= ~next_status.bus_off;
            RX_ENABLE <= ~next_status.bus_off;
        end
    end

    // error-frame counters: events from the controller, loads from software
    assign cnt_a.evt = TX_ERR_FRAME;
    assign cnt_a.evt_data = `CESM_WORD_RST;
    assign cnt_a.load = PAR_WR && (PAR_INDEX == `CESM_IDX_COUNT_A);
    assign cnt_a.load_data = PAR_WDATA;
    assign cnt_b.evt = RX_ERR_FRAME;
    assign cnt_b.evt_data = `CESM_WORD_RST;
    assign cnt_b.load = PAR_WR && (PAR_INDEX == `CESM_IDX_COUNT_B);
    assign cnt_b.load_data = PAR_WDATA;

    cesm_frame_counter u_count_a (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .w(cnt_a)
    );

    cesm_frame_counter u_count_b (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .w(cnt_b)
    );

    // main-fault details with comm-error bits masked out
    assign dev_detail = MAIN_FAULT_WORD & ~`CESM_COMM_FAULT_MASK;

    // emergency records; a write to the entry count clears all three
    assign rec_svc.evt = EMCY_SVC_EVT;
    assign rec_svc.evt_data = EMCY_SVC_DATA;
    assign rec_svc.load = PAR_WR && (PAR_INDEX == `CESM_IDX_EMCY_ENTRIES);
    assign rec_svc.load_data = `CESM_WORD_RST;
    assign rec_pdo.evt = EMCY_PDO_EVT;
    assign rec_pdo.evt_data = EMCY_PDO_DATA;
    assign rec_pdo.load = rec_svc.load;
    assign rec_pdo.load_data = `CESM_WORD_RST;
    assign rec_dev.evt = |dev_detail;
    assign rec_dev.evt_data = dev_detail;
    assign rec_dev.load = rec_svc.load;
    assign rec_dev.load_data = `CESM_WORD_RST;

    cesm_emcy_record u_rec_service (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .w(rec_svc)
    );

    cesm_emcy_record u_rec_process (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .w(rec_pdo)
    );

    cesm_emcy_record u_rec_device (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .w(rec_dev)
    );

    // emergency entry count: starts at 3, keeps the low byte of whatever software writes
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            emcy_entries <= `CESM_EMCY_ENTRIES_RST;
        end else if (rec_svc.load) begin
            emcy_entries <= PAR_WDATA[7:0];
        end
    end

    // read multiplexer; narrow entries sit in the low byte
    always_comb begin
        next_rdata = `CESM_WORD_RST;
        if (PAR_INDEX == `CESM_IDX_GROUP_ENTRIES) begin
            next_rdata = {24'h00_0000, `CESM_GROUP_ENTRIES};
        end else if (PAR_INDEX == `CESM_IDX_STATUS) begin
            next_rdata = status;
        end else if (PAR_INDEX == `CESM_IDX_COUNT_A) begin
            next_rdata = cnt_a.value;
        end else if (PAR_INDEX == `CESM_IDX_COUNT_B) begin
            next_rdata = cnt_b.value;
        end else if (PAR_INDEX == `CESM_IDX_EMCY_ENTRIES) begin
            next_rdata = {24'h00_0000, emcy_entries};
        end else if (PAR_INDEX == `CESM_IDX_EMCY_SERVICE) begin
            next_rdata = rec_svc.value;
        end else if (PAR_INDEX == `CESM_IDX_EMCY_PROCESS) begin
            next_rdata = rec_pdo.value;
        end else if (PAR_INDEX == `CESM_IDX_EMCY_DEVICE) begin
            next_rdata = rec_dev.value;
        end
    end

    // refuse unknown indices and writes to read-only ones
    always_comb begin
        next_err = 1'b0;
        if ((PAR_RD || PAR_WR) && !index_hit(PAR_INDEX)) begin
            next_err = 1'b1;
        end else if (PAR_WR && !index_writable(PAR_INDEX)) begin
            next_err = 1'b1;
        end
    end

    // answer one cycle after the request; read data holds until the next read
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            PAR_RDATA <= `CESM_WORD_RST;
        end else if (PAR_RD) begin
            PAR_RDATA <= next_rdata;
        end
    end

    // acknowledge and error are one-cycle pulses
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            PAR_ACK <= 1'b0;
            PAR_ERR <= 1'b0;
        end else begin
            PAR_ACK <= PAR_RD || PAR_WR;
            PAR_ERR <= next_err;
        end
    end

    // checks on the status word, counters and records
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);

    a_warn_level: assert property (
        (TX_ERR_CNT >= 9'h060 || RX_ERR_CNT >= 8'h60) |=> status.warning)
        else $error("warning bit missing at count 96");
    a_warn_clear: assert property (
        (TX_ERR_CNT < 9'h060 && RX_ERR_CNT < 8'h60) |=> !status.warning)
        else $error("warning bit set below 96");
    a_passive_level: assert property (
        ##1 (status.passive == ($past(TX_ERR_CNT) >= 9'h080)))
        else $error("passive bit wrong for tec threshold 128");
    a_bus_off_gate: assert property (
        (TX_ERR_CNT >= 9'h100) |=> (status.bus_off && !TX_ENABLE && !RX_ENABLE))
        else $error("bus-off not flagged or bus not blocked");
    a_bus_off_free: assert property (
        (TX_ERR_CNT < 9'h100) |=> (!status.bus_off && TX_ENABLE && RX_ENABLE))
        else $error("bus blocked without bus-off");
    a_err_flags: assert property (
        ##1 (STATUS_WORD[8:3] == $past(ERR_TYPE)))
        else $error("error-type flags do not follow controller");
    a_tec_field: assert property (
        (TX_ERR_CNT < 9'h100) |=> (STATUS_WORD[23:16] == $past(TX_ERR_CNT[7:0])))
        else $error("tec field wrong");
    a_rec_field: assert property (
        ##1 (STATUS_WORD[31:24] == $past(RX_ERR_CNT)))
        else $error("rec field wrong");
    a_reserved_zero: assert property (
        PAR_RD && PAR_INDEX == `CESM_IDX_STATUS |=> PAR_RDATA[15:9] == 7'h00)
        else $error("reserved status bits read nonzero");
    a_status_write_err: assert property (
        PAR_WR && PAR_INDEX == `CESM_IDX_STATUS |=> PAR_ERR && PAR_ACK)
        else $error("status write not refused");
    a_frame_inc: assert property (
        TX_ERR_FRAME && !cnt_a.load |=> cnt_a.value == $past(cnt_a.value) + 32'h0000_0001)
        else $error("frame counter a did not step");
    a_frame_load: assert property (
        PAR_WR && PAR_INDEX == `CESM_IDX_COUNT_B && !RX_ERR_FRAME
        |=> cnt_b.value == $past(PAR_WDATA))
        else $error("frame counter b did not load");
    a_emcy_clear: assert property (
        PAR_WR && PAR_INDEX == `CESM_IDX_EMCY_ENTRIES && !EMCY_SVC_EVT && !EMCY_PDO_EVT
        && !rec_dev.evt |=> (rec_svc.value | rec_pdo.value | rec_dev.value) == 32'h0)
        else $error("emergency records not cleared");
    a_svc_capture: assert property (
        EMCY_SVC_EVT |=> (rec_svc.value & $past(EMCY_SVC_DATA)) == $past(EMCY_SVC_DATA))
        else $error("service detail not captured");
    a_pdo_capture: assert property (
        EMCY_PDO_EVT |=> (rec_pdo.value & $past(EMCY_PDO_DATA)) == $past(EMCY_PDO_DATA))
        else $error("process detail not captured");
    a_dev_no_comm: assert property (
        !rec_dev.load |=> (rec_dev.value & `CESM_COMM_FAULT_MASK) ==
        ($past(rec_dev.value) & `CESM_COMM_FAULT_MASK))
        else $error("comm error entered device record");
    a_group_const: assert property (
        PAR_RD && PAR_INDEX == `CESM_IDX_GROUP_ENTRIES |=> PAR_RDATA == 32'h0000_0005)
        else $error("counter group entry count not 5");

    // counters, records and entry counts; the hold checks catch a record that drifts
    a_count_a_load: assert property (
        PAR_WR && PAR_INDEX == `CESM_IDX_COUNT_A
        |=> cnt_a.value == $past(PAR_WDATA) + {31'h0000_0000, $past(TX_ERR_FRAME)})
        else $error("frame counter a did not load");
    a_count_b_inc: assert property (
        RX_ERR_FRAME && !cnt_b.load |=> cnt_b.value == $past(cnt_b.value) + 32'h0000_0001)
        else $error("frame counter b did not step");
    a_svc_keep: assert property (
        !EMCY_SVC_EVT && !rec_svc.load |=> $stable(rec_svc.value))
        else $error("service detail changed without event");
    a_pdo_keep: assert property (
        !EMCY_PDO_EVT && !rec_pdo.load |=> $stable(rec_pdo.value))
        else $error("process detail changed without event");
    a_dev_capture: assert property (
        rec_dev.evt |=> (rec_dev.value & $past(dev_detail)) == $past(dev_detail))
        else $error("device detail not captured");
    a_dev_keep: assert property (
        !rec_dev.evt && !rec_dev.load |=> $stable(rec_dev.value))
        else $error("device detail changed without fault");
    a_entries_load: assert property (
        PAR_WR && PAR_INDEX == `CESM_IDX_EMCY_ENTRIES
        |=> emcy_entries == $past(PAR_WDATA[7:0]))
        else $error("emergency entry count did not take written byte");
    a_group_no_write: assert property (
        PAR_WR && PAR_INDEX == `CESM_IDX_GROUP_ENTRIES |=> PAR_ERR && PAR_ACK)
        else $error("counter group write not refused");

    // live status word fields and readback; transmit and receive gating kept equal
    a_tec_saturate: assert property (
        TX_ERR_CNT >= `CESM_LIM_BUS_OFF |=> STATUS_WORD[23:16] == 8'hff)
        else $error("tec field not saturated in bus-off");
    a_reserved_live: assert property (
        STATUS_WORD[15:9] == 7'h00)
        else $error("reserved status bits nonzero");
    a_status_readback: assert property (
        PAR_RD && PAR_INDEX == `CESM_IDX_STATUS |=> PAR_RDATA == $past(STATUS_WORD))
        else $error("status readback differs from live word");
    a_enable_pair: assert property (
        TX_ENABLE == RX_ENABLE)
        else $error("transmit and receive gating disagree");

    c_bus_off: cover property (TX_ERR_CNT >= 9'h100 ##1 !TX_ENABLE);
    c_frame_during_load: cover property (TX_ERR_FRAME && cnt_a.load);
    c_clear_with_capture: cover property (rec_svc.load && EMCY_SVC_EVT);
    c_unmapped_read: cover property (PAR_RD && !index_hit(PAR_INDEX) ##1 PAR_ERR);
    c_emcy_cleared: cover property (rec_svc.load ##1 (rec_pdo.value == 32'h0000_0000));

endmodule

/* File: dv/cesm_can_peer.sv */
// behavioural protocol controller standing beside the monitor: error counters,
// live error-type levels and error-frame pulses
// assumes it shares REF_CLK with the monitor and is steered by the bench tasks
`timescale 1ns/1ps
module cesm_can_peer (
    // clock
    input wire logic clk,
    // controller view towards the monitor
    output logic [8:0] tec,
    output logic [7:0] rec,
    output logic [5:0] err_type,
    output logic tx_frame,
    output logic rx_frame
);
    // quiet controller at time zero: error-active, no frames in flight
    initial begin
        tec = 9'h000;
        rec = 8'h00;
        err_type = 6'h00;
        tx_frame = 1'b0;
        rx_frame = 1'b0;
    end

    // counters are levels; a real controller moves them only after an edge
    task automatic drive(input logic [8:0] t, input logic [7:0] r, input logic [5:0] e);
        @(posedge clk);
        #1;
        tec = t;
        rec = r;
        err_type = e;
    endtask

    // one-cycle error-frame pulses, released the cycle after so none is counted twice
    task automatic pulse(input logic a, input logic b);
        @(posedge clk);
        #1;
        tx_frame = a;
        rx_frame = b;
        @(posedge clk);
        #1;
        tx_frame = 1'b0;
        rx_frame = 1'b0;
    endtask
endmodule

/* File: dv/tb_cesm_monitor.sv */
// self-checking bench for the bus-port error status monitor
// assumes the monitor answers parameter strobes one cycle later, never stalling
`timescale 1ns/1ps
`include "cesm_map.svh"
module tb_cesm_monitor;
    logic clk, rst, svc_evt, pdo_evt, rd, wr, ack, err, tx_en, rx_en, txf, rxf;
    logic [8:0] tec;
    logic [7:0] rec;
    logic [5:0] etype;
    logic [15:0] idx;
    logic [31:0] svc_data, pdo_data, main_fault, wdata, rdata, status, seed, d;
    int n_fail, check_count, cycles, cnt_a, cnt_b, n;
    logic [31:0] r_svc, r_pdo, r_dev;
    int tl[9] = '{0, 95, 96, 127, 128, 255, 256, 300, 511};
    int rl[9] = '{0, 96, 95, 255, 10, 97, 0, 200, 255};

    cesm_can_peer cesm_can_peer_inst (.clk(clk), .tec(tec), .rec(rec), .err_type(etype),
        .tx_frame(txf), .rx_frame(rxf));

    cesm_monitor cesm_monitor_inst (.REF_CLK(clk), .SYS_RST(rst), .TX_ERR_CNT(tec),
        .RX_ERR_CNT(rec), .ERR_TYPE(etype), .TX_ERR_FRAME(txf), .RX_ERR_FRAME(rxf),
        .EMCY_SVC_EVT(svc_evt), .EMCY_SVC_DATA(svc_data), .EMCY_PDO_EVT(pdo_evt),
        .EMCY_PDO_DATA(pdo_data), .MAIN_FAULT_WORD(main_fault), .PAR_INDEX(idx),
        .PAR_RD(rd), .PAR_WR(wr), .PAR_WDATA(wdata), .PAR_RDATA(rdata), .PAR_ACK(ack),
        .PAR_ERR(err), .TX_ENABLE(tx_en), .RX_ENABLE(rx_en), .STATUS_WORD(status));

    // free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // xorshift source, fixed start so every run is the same
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // status word as the fault-confinement rules build it
    function automatic logic [31:0] exp_status(input int t, input int r, input logic [5:0] e);
        logic [31:0] s;
        s = 32'h0000_0000;
        s[0] = (t >= 96) || (r >= 96);
        s[1] = (t >= 128);
        s[2] = (t >= 256);
        s[8:3] = e;
        s[23:16] = (t > 255) ? 8'hff : 8'(t);
        s[31:24] = 8'(r);
        return s;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one strobe on the parameter port; ack, refusal and read data are seen one cycle on
    task automatic par(input logic r, input logic w, input logic [15:0] i,
                       input logic [31:0] dw, input logic [31:0] exp, input logic exp_err);
        @(posedge clk);
        #1;
        rd = r;
        wr = w;
        idx = i;
        wdata = dw;
        @(posedge clk);
        #1;
        rd = 1'b0;
        wr = 1'b0;
        chk({31'h0, ack}, 32'h1);
        chk({31'h0, err}, {31'h0, exp_err});
        if (r) begin
            chk(rdata, exp);
        end
    endtask

    // one emergency event from the service or the process-data source
    task automatic emcy(input logic s, input logic [31:0] dv);
        @(posedge clk);
        #1;
        svc_evt = s;
        pdo_evt = !s;
        svc_data = dv;
        pdo_data = dv;
        @(posedge clk);
        #1;
        svc_evt = 1'b0;
        pdo_evt = 1'b0;
    endtask

    task automatic tally_and_finish;
        if (n_fail == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    initial begin
        {rst, svc_evt, pdo_evt, rd, wr} = 5'b10000;
        {svc_data, pdo_data, main_fault, wdata} = {4{32'h0000_0000}};
        idx = 16'h0000;
        seed = 32'h0001_6dd0;
        {n_fail, check_count, cycles, cnt_a, cnt_b} = '0;
        {r_svc, r_pdo, r_dev} = {3{32'h0000_0000}};
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        // values straight after reset
        par(1'b1, 1'b0, `CESM_IDX_GROUP_ENTRIES, 32'h0, 32'h5, 1'b0);
        par(1'b1, 1'b0, `CESM_IDX_EMCY_ENTRIES, 32'h0, 32'h3, 1'b0);
        par(1'b1, 1'b0, `CESM_IDX_COUNT_A, 32'h0, 32'h0, 1'b0);
        // threshold table with random error-type levels, live word and indexed read
        for (int i = 0; i < 9; i++) begin
            d = rnd();
            cesm_can_peer_inst.drive(9'(tl[i]), 8'(rl[i]), d[5:0]);
            @(posedge clk);
            #1;
            chk(status, exp_status(tl[i], rl[i], d[5:0]));
            chk({30'h0, tx_en, rx_en}, {30'h0, {2{tl[i] < 256}}});
            par(1'b1, 1'b0, `CESM_IDX_STATUS, 32'h0, exp_status(tl[i], rl[i], d[5:0]), 1'b0);
        end
        // status and counter group refuse writes; status keeps its value
        par(1'b1, 1'b1, `CESM_IDX_STATUS, 32'hffff_ffff, exp_status(511, 255, d[5:0]), 1'b1);
        par(1'b1, 1'b0, `CESM_IDX_STATUS, 32'h0, exp_status(511, 255, d[5:0]), 1'b0);
        par(1'b0, 1'b1, `CESM_IDX_GROUP_ENTRIES, 32'h0, 32'h0, 1'b1);
        par(1'b1, 1'b0, 16'h0430, 32'h0, 32'h0, 1'b1);
        // error-frame counters: random pulses, wrap, write with pulse in the same cycle
        n = int'(rnd() % 6) + 1;
        for (int i = 0; i < n; i++) begin
            d = rnd();
            cesm_can_peer_inst.pulse(d[0], d[1]);
            cnt_a += int'(d[0]);
            cnt_b += int'(d[1]);
        end
        par(1'b1, 1'b0, `CESM_IDX_COUNT_A, 32'h0, 32'(cnt_a), 1'b0);
        par(1'b1, 1'b0, `CESM_IDX_COUNT_B, 32'h0, 32'(cnt_b), 1'b0);
        par(1'b0, 1'b1, `CESM_IDX_COUNT_B, 32'hffff_ffff, 32'h0, 1'b0);
        cesm_can_peer_inst.pulse(1'b0, 1'b1);
        par(1'b1, 1'b0, `CESM_IDX_COUNT_B, 32'h0, 32'h0, 1'b0);
        d = rnd();
        fork
            par(1'b0, 1'b1, `CESM_IDX_COUNT_A, d, 32'h0, 1'b0);
            cesm_can_peer_inst.pulse(1'b1, 1'b0);
        join
        par(1'b1, 1'b0, `CESM_IDX_COUNT_A, 32'h0, d + 32'h1, 1'b0);
        // emergency records gather events until a write to the entry count clears them
        for (int i = 0; i < 3; i++) begin
            d = rnd();
            emcy(1'b1, d);
            r_svc |= d;
            d = rnd();
            emcy(1'b0, d);
            r_pdo |= d;
        end
        d = rnd() | 32'h0000_0001;
        @(posedge clk);
        #1;
        main_fault = d;
        r_dev = d & ~`CESM_COMM_FAULT_MASK;
        @(posedge clk);
        #1;
        main_fault = 32'h0000_0000;
        par(1'b1, 1'b0, `CESM_IDX_EMCY_SERVICE, 32'h0, r_svc, 1'b0);
        par(1'b1, 1'b0, `CESM_IDX_EMCY_PROCESS, 32'h0, r_pdo, 1'b0);
        par(1'b1, 1'b0, `CESM_IDX_EMCY_DEVICE, 32'h0, r_dev, 1'b0);
        par(1'b0, 1'b1, `CESM_IDX_EMCY_SERVICE, 32'h0, 32'h0, 1'b1);
        par(1'b1, 1'b1, `CESM_IDX_EMCY_DEVICE, 32'h0, r_dev, 1'b1);
        d = rnd();
        par(1'b0, 1'b1, `CESM_IDX_EMCY_ENTRIES, d, 32'h0, 1'b0);
        par(1'b1, 1'b0, `CESM_IDX_EMCY_ENTRIES, 32'h0, {24'h0, d[7:0]}, 1'b0);
        par(1'b1, 1'b0, `CESM_IDX_EMCY_SERVICE, 32'h0, 32'h0, 1'b0);
        par(1'b1, 1'b0, `CESM_IDX_EMCY_PROCESS, 32'h0, 32'h0, 1'b0);
        par(1'b1, 1'b0, `CESM_IDX_EMCY_DEVICE, 32'h0, 32'h0, 1'b0);
        // mid-run reset: held values drop to reset state, live values return one edge on
        emcy(1'b0, 32'h0000_00a5);
        cesm_can_peer_inst.drive(9'h000, 8'h00, 6'h00);
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        chk(status, 32'h0000_0000);
        chk({30'h0, tx_en, rx_en}, 32'h0);
        @(posedge clk);
        #1;
        chk({30'h0, tx_en, rx_en}, 32'h3);
        par(1'b1, 1'b0, `CESM_IDX_EMCY_ENTRIES, 32'h0, 32'h3, 1'b0);
        par(1'b1, 1'b0, `CESM_IDX_COUNT_A, 32'h0, 32'h0, 1'b0);
        par(1'b1, 1'b0, `CESM_IDX_EMCY_PROCESS, 32'h0, 32'h0, 1'b0);
        tally_and_finish();
    end
endmodule
